// ==== hil_pkg.sv ====
package hil_pkg;

  // Sizes
  localparam int AXES = 4;
  localparam int KEYS = 4;
  localparam int AW   = 8;
  localparam int DW   = 32;
  localparam int FW   = 16;  // Factor word, tenths of mm per revolution
  localparam int IW   = 8;   // Increment per strobe
  localparam int PW   = 16;  // Pending increment accumulator
  localparam int TW   = 32;  // Travel result
  localparam int MAW  = 4;

  // Register offsets
  localparam logic [AW-1:0] OFS_KEY_NOW = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS  = 8'h04;
  localparam logic [AW-1:0] OFS_FILTER  = 8'h08;
  localparam logic [AW-1:0] OFS_LATCH   = 8'h10;  // +4*k, k=0 all
  localparam logic [AW-1:0] OFS_LAT_END = 8'h20;
  localparam logic [AW-1:0] OFS_FACT    = 8'h40;  // 12 factor words
  localparam logic [AW-1:0] OFS_FAC_END = 8'h6c;
  localparam logic [AW-1:0] OFS_HW_ALL  = 8'h70;
  localparam logic [AW-1:0] OFS_HWB_ALL = 8'h74;
  localparam logic [AW-1:0] OFS_TB_ALL  = 8'h78;

  // Field positions
  localparam int ST_BUSY  = 0;
  localparam int ST_ALT   = 1;
  localparam int ST_SWP   = 2;
  localparam int CNT_LSB  = 8;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_ALL = 3'h4;

  // Factor memory layout
  localparam int MDEPTH   = 12;
  localparam logic [MAW-1:0] MIDX_HW  = 4'h0;
  localparam logic [MAW-1:0] MIDX_HWB = 4'h4;
  localparam logic [MAW-1:0] MIDX_TB  = 4'h8;

  // Reset values and range, factors in units of 0.1
  localparam logic        FILTER_RST = 1'b1;
  localparam logic signed [FW-1:0] FACT_ONE = 16'sh000a;
  localparam logic signed [FW-1:0] HW_RST   = 16'sh000a;
  localparam logic signed [FW-1:0] FACT_MAX = 16'sh07d0;  // 200.0
  localparam logic signed [FW-1:0] FACT_MIN = -16'sh07d0;

  // Handwheel scale: one step of factor 0.1 mm/rev in nanometres
  localparam int STEPS_PER_REV = 100000;
  localparam int NM_PER_TENTH  = 100000;
  localparam int HW_NM_SCALE   = NM_PER_TENTH / STEPS_PER_REV;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_HW   = 2'h1,
    ENG_TB   = 2'h3,
    ENG_MUL  = 2'h2
  } hil_eng_type;

endpackage : hil_pkg

// ==== hil_fmem.sv ====
`timescale 1ns/1ps
`default_nettype none
module hil_fmem (
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  input  wire logic [hil_pkg::MDEPTH-1:0]  wr_en_i,
  input  wire logic [hil_pkg::FW-1:0]      wr_data_i,
  input  wire logic [hil_pkg::MAW-1:0]     a_addr_i,
  output logic      [hil_pkg::FW-1:0]      a_data_o,
  input  wire logic [hil_pkg::MAW-1:0]     b_addr_i,
  output logic      [hil_pkg::FW-1:0]      b_data_o
);
  import hil_pkg::*;

  logic [FW-1:0] mem_q [MDEPTH];
  logic [FW-1:0] a_d;
  logic [FW-1:0] b_d;

  // One flop word per entry; trackball words reset to unity gain
  for (genvar i = 0; i < MDEPTH; i++) begin : g_word
    localparam logic [FW-1:0] RST = (i >= 8) ? FACT_ONE : HW_RST;
    logic [FW-1:0] word_d;
    always_comb begin
      word_d = wr_en_i[i] ? wr_data_i : mem_q[i];
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        mem_q[i] <= RST;
      end else begin
        mem_q[i] <= word_d;
      end
    end
  end

  // Two read ports, beyond the depth reads zero
  always_comb begin
    a_d = (32'(a_addr_i) < MDEPTH) ? mem_q[a_addr_i] : '0;
    b_d = (32'(b_addr_i) < MDEPTH) ? mem_q[b_addr_i] : '0;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_data_o <= '0;
      b_data_o <= '0;
    end else begin
      a_data_o <= a_d;
      b_data_o <= b_d;
    end
  end

endmodule : hil_fmem
`default_nettype wire

// ==== hil_nfilt.sv ====
`timescale 1ns/1ps
`default_nettype none
module hil_nfilt (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  en_i,
  input  wire logic                  take_i,
  input  wire logic [hil_pkg::PW-1:0] raw_i,
  output logic      [hil_pkg::PW-1:0] filt_o
);
  import hil_pkg::*;

  logic              res_q;
  logic              res_d;
  logic signed [PW-1:0] sum;

  // Odd step held back as residue; a one-step dither nets to zero
  always_comb begin
    sum    = $signed(raw_i) + $signed({{(PW-1){1'b0}}, res_q});
    filt_o = en_i ? {sum[PW-1:1], 1'b0} : raw_i;
    res_d  = res_q;
    if (take_i) begin
      res_d = en_i & sum[0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_q <= 1'b0;
    end else begin
      res_q <= res_d;
    end
  end

endmodule : hil_nfilt
`default_nettype wire

// ==== hil_hand_input.sv ====
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hil_hand_input (
  input  wire logic                              clock_i,
  input  wire logic                              rst_b_i,
  input  wire logic [hil_pkg::AW-1:0]            bus_addr_i,
  input  wire logic [hil_pkg::DW-1:0]            bus_wdata_i,
  input  wire logic                              bus_wr_i,
  input  wire logic                              bus_rd_i,
  output logic      [hil_pkg::DW-1:0]            bus_rdata_o,
  input  wire logic [hil_pkg::KEYS-1:0]          key_i,
  input  wire logic                              fsw_present_i,
  input  wire logic                              fsw_alt_i,
  input  wire logic                              inc_strobe_i,
  input  wire logic [hil_pkg::AXES-1:0][hil_pkg::IW-1:0] hw_inc_i,
  input  wire logic [hil_pkg::AXES-1:0][hil_pkg::IW-1:0] tb_inc_i,
  output logic      [hil_pkg::AXES-1:0][hil_pkg::TW-1:0] hw_travel_o,
  output logic      [hil_pkg::AXES-1:0][hil_pkg::TW-1:0] tb_travel_o,
  output logic                                   travel_valid_o
);
  import hil_pkg::*;

  // Key latches and filter enable
  logic [KEYS-1:0] latch_q;
  logic [KEYS-1:0] latch_d;
  logic [KEYS-1:0] lat_clr;
  logic            filt_en_q;
  logic            filt_en_d;

  // Bus decode and read path
  logic            lat_hit;
  logic [2:0]      lat_sel;
  logic            fac_hit;
  logic [MAW-1:0]  fac_idx;
  logic [AW-1:0]   lat_off;
  logic [AW-1:0]   fac_off;
  logic [DW-1:0]   rdata_q;
  logic [DW-1:0]   rdata_d;
  logic            rd_mem_q;
  logic            rd_mem_d;
  logic [MDEPTH-1:0] mem_we;
  logic [FW-1:0]   mem_wdata;
  logic [FW-1:0]   mem_a_data;
  logic [FW-1:0]   mem_b_data;
  logic [MAW-1:0]  mem_b_addr;

  // Increment collection and scaling engine
  logic            have_q;
  logic            have_d;
  logic            snap;
  logic            use_alt;
  logic [AXES-1:0][PW-1:0] pend_hw_q;
  logic [AXES-1:0][PW-1:0] pend_hw_d;
  logic [AXES-1:0][PW-1:0] pend_tb_q;
  logic [AXES-1:0][PW-1:0] pend_tb_d;
  logic [AXES-1:0][PW-1:0] hw_in;
  logic [AXES-1:0][PW-1:0] work_hw_q;
  logic [AXES-1:0][PW-1:0] work_hw_d;
  logic [AXES-1:0][PW-1:0] work_tb_q;
  logic [AXES-1:0][PW-1:0] work_tb_d;
  logic [AXES-1:0][TW-1:0] hw_trav_q;
  logic [AXES-1:0][TW-1:0] hw_trav_d;
  logic [AXES-1:0][TW-1:0] tb_trav_q;
  logic [AXES-1:0][TW-1:0] tb_trav_d;
  logic [1:0]      ax_q;
  logic [1:0]      ax_d;
  logic            valid_q;
  logic            valid_d;
  hil_eng_type     eng_q;
  hil_eng_type     eng_d;

  // Out-of-range writes clamp instead of wrapping into the wrong sign
  function automatic logic [FW-1:0] clamp_f(input logic [DW-1:0] v);
    logic signed [DW-1:0] s;
    s = $signed(v);
    if (s > $signed(FACT_MAX)) begin
      return FACT_MAX;
    end else if (s < $signed(FACT_MIN)) begin
      return FACT_MIN;
    end
    return v[FW-1:0];
  endfunction : clamp_f

  // Address decode of the latch window and factor window
  always_comb begin
    lat_off = bus_addr_i - OFS_LATCH;
    fac_off = bus_addr_i - OFS_FACT;
    lat_hit = (bus_addr_i >= OFS_LATCH) && (bus_addr_i <= OFS_LAT_END)
              && (bus_addr_i[1:0] == 2'h0);
    lat_sel = lat_off[4:2];
    fac_hit = (bus_addr_i >= OFS_FACT) && (bus_addr_i <= OFS_FAC_END)
              && (bus_addr_i[1:0] == 2'h0);
    fac_idx = fac_off[5:2];
  end

  // Latch clear from read-and-clear or clear-only write
  always_comb begin
    lat_clr = '0;
    if (lat_hit && (bus_rd_i || bus_wr_i)) begin
      if (lat_sel == 3'h0) begin
        lat_clr = '1;
      end else begin
        lat_clr[lat_sel[1:0] - 2'h1] = 1'b1;
      end
    end
    // Fresh press wins over a clear in the same cycle
    latch_d = (latch_q & ~lat_clr) | key_i;
  end

  // Filter enable register, one bit for X and Y together
  always_comb begin
    filt_en_d = filt_en_q;
    if (bus_wr_i && (bus_addr_i == OFS_FILTER)) begin
      filt_en_d = bus_wdata_i[0];
    end
  end

  // Factor writes: one word, or one kind broadcast to every axis
  always_comb begin
    mem_we    = '0;
    mem_wdata = clamp_f(bus_wdata_i);
    if (bus_wr_i) begin
      if (fac_hit) begin
        mem_we[fac_idx] = 1'b1;
      end else if (bus_addr_i == OFS_HW_ALL) begin
        mem_we[3:0] = '1;
      end else if (bus_addr_i == OFS_HWB_ALL) begin
        mem_we[7:4] = '1;
      end else if (bus_addr_i == OFS_TB_ALL) begin
        mem_we[11:8] = '1;
      end
    end
  end

  // Read data for local registers; factor words come from memory
  always_comb begin
    rdata_d  = '0;
    rd_mem_d = bus_rd_i && fac_hit;
    if (bus_rd_i) begin
      if (bus_addr_i == OFS_KEY_NOW) begin
        rdata_d[KEYS-1:0] = key_i;
      end else if (bus_addr_i == OFS_STATUS) begin
        rdata_d[ST_BUSY] = (eng_q != ENG_IDLE);
        rdata_d[ST_ALT]  = use_alt;
        rdata_d[ST_SWP]  = fsw_present_i;
      end else if (bus_addr_i == OFS_FILTER) begin
        rdata_d[0] = filt_en_q;
      end else if (lat_hit) begin
        // Zero means no press seen since the last read or clear-only write of this word or the all word
        if (lat_sel == 3'h0) begin
          rdata_d[KEYS-1:0]       = latch_q;
          rdata_d[CNT_LSB +: 3]   = CNT_ALL;
        end else begin
          rdata_d[0]              = latch_q[lat_sel[1:0] - 2'h1];
          rdata_d[CNT_LSB +: 3]   = CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_q   <= '0;
      filt_en_q <= FILTER_RST;
      rdata_q   <= '0;
      rd_mem_q  <= 1'b0;
    end else begin
      latch_q   <= latch_d;
      filt_en_q <= filt_en_d;
      rdata_q   <= rdata_d;
      rd_mem_q  <= rd_mem_d;
    end
  end

  // Factor words, signed, sign extended onto the bus
  assign bus_rdata_o = rd_mem_q ? {{(DW-FW){mem_a_data[FW-1]}}, mem_a_data}
                                : rdata_q;

  hil_fmem u_fmem (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (mem_we),
    .wr_data_i (mem_wdata),
    .a_addr_i  (fac_idx),
    .a_data_o  (mem_a_data),
    .b_addr_i  (mem_b_addr),
    .b_data_o  (mem_b_data)
  );

  // Alternate factor only when the device really has the switch
  assign use_alt = fsw_present_i & fsw_alt_i;

  // Noise filter on the X and Y handwheels only
  for (genvar a = 0; a < AXES; a++) begin : g_filt
    if (a < 2) begin : g_on
      hil_nfilt u_nfilt (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .en_i    (filt_en_q),
        .take_i  (snap),
        .raw_i   (pend_hw_q[a]),
        .filt_o  (hw_in[a])
      );
    end else begin : g_off
      assign hw_in[a] = pend_hw_q[a];
    end
  end

  // Strobes keep accumulating while the engine works a snapshot
  always_comb begin
    snap   = (eng_q == ENG_IDLE) && have_q;
    have_d = inc_strobe_i | (have_q & ~snap);
    for (int a = 0; a < AXES; a++) begin
      pend_hw_d[a] = snap ? '0 : pend_hw_q[a];
      pend_tb_d[a] = snap ? '0 : pend_tb_q[a];
      if (inc_strobe_i) begin
        pend_hw_d[a] = pend_hw_d[a]
                     + {{(PW-IW){hw_inc_i[a][IW-1]}}, hw_inc_i[a]};
        pend_tb_d[a] = pend_tb_d[a]
                     + {{(PW-IW){tb_inc_i[a][IW-1]}}, tb_inc_i[a]};
      end
    end
  end

  // Engine: per axis, fetch handwheel factor, then trackball gain
  always_comb begin
    eng_d      = eng_q;
    ax_d       = ax_q;
    valid_d    = 1'b0;
    work_hw_d  = work_hw_q;
    work_tb_d  = work_tb_q;
    hw_trav_d  = hw_trav_q;
    tb_trav_d  = tb_trav_q;
    mem_b_addr = MIDX_TB;
    case (eng_q)
      ENG_IDLE: begin
        if (snap) begin
          work_hw_d = hw_in;
          work_tb_d = pend_tb_q;
          ax_d      = 2'h0;
          eng_d     = ENG_HW;
        end
      end
      ENG_HW: begin
        mem_b_addr = (use_alt ? MIDX_HWB : MIDX_HW) + {2'h0, ax_q};
        eng_d      = ENG_TB;
      end
      ENG_TB: begin
        // Factor in tenths times steps gives nanometres; a negative factor flips the sign
        mem_b_addr    = MIDX_TB + {2'h0, ax_q};
        hw_trav_d[ax_q] = TW'($signed(work_hw_q[ax_q])
                        * $signed(mem_b_data) * HW_NM_SCALE);
        eng_d         = ENG_MUL;
      end
      ENG_MUL: begin
        tb_trav_d[ax_q] = TW'($signed(work_tb_q[ax_q])
                        * $signed(mem_b_data));
        if (ax_q == 2'h3) begin
          valid_d = 1'b1;
          eng_d   = ENG_IDLE;
        end else begin
          ax_d  = ax_q + 2'h1;
          eng_d = ENG_HW;
        end
      end
      default: begin
        eng_d = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      have_q    <= 1'b0;
      pend_hw_q <= '0;
      pend_tb_q <= '0;
      work_hw_q <= '0;
      work_tb_q <= '0;
      hw_trav_q <= '0;
      tb_trav_q <= '0;
      ax_q      <= 2'h0;
      valid_q   <= 1'b0;
      eng_q     <= ENG_IDLE;
    end else begin
      have_q    <= have_d;
      pend_hw_q <= pend_hw_d;
      pend_tb_q <= pend_tb_d;
      work_hw_q <= work_hw_d;
      work_tb_q <= work_tb_d;
      hw_trav_q <= hw_trav_d;
      tb_trav_q <= tb_trav_d;
      ax_q      <= ax_d;
      valid_q   <= valid_d;
      eng_q     <= eng_d;
    end
  end

  // Results stand until the next pass overwrites them
  assign hw_travel_o    = hw_trav_q;
  assign tb_travel_o    = tb_trav_q;
  assign travel_valid_o = valid_q;

endmodule : hil_hand_input
`default_nettype wire

// ==== hil_hand_input_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module hil_hand_input_asserts
  import hil_pkg::*;
(
  input wire logic          clock_i,
  input wire logic          rst_b_i,
  input wire logic [AW-1:0] bus_addr_i,
  input wire logic [DW-1:0] bus_wdata_i,
  input wire logic          bus_wr_i,
  input wire logic          bus_rd_i,
  input wire logic [DW-1:0] bus_rdata_o,
  input wire logic [3:0]    key_i,
  input wire logic          inc_strobe_i,
  input wire logic          travel_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // Bus steps used by the read-back checks
  sequence s_rd(logic [AW-1:0] a);
    bus_rd_i && bus_addr_i == a;
  endsequence
  sequence s_wr(logic [AW-1:0] a);
    bus_wr_i && bus_addr_i == a;
  endsequence
  sequence s_rd_free;
    bus_rd_i && bus_addr_i == 8'h18 && !key_i[1];
  endsequence
  sequence s_big;
    s_wr(OFS_FACT) ##0 $signed(bus_wdata_i) > 32'sd2000;
  endsequence

  idle_rdata_a: assert property (!$past(bus_rd_i) |-> bus_rdata_o == '0)
    else $error("read data not zero outside a read");
  live_key_a: assert property (s_rd(OFS_KEY_NOW) |=>
    bus_rdata_o == {28'h0, $past(key_i)}) else $error("live keys wrong");
  one_count_a: assert property (s_rd(8'h18) |=>
    bus_rdata_o[31:1] == 31'h80) else $error("single latch word wrong");
  all_count_a: assert property (s_rd(OFS_LATCH) |=>
    bus_rdata_o[31:4] == 28'h40) else $error("all latch word wrong");
  latch_set_a: assert property (key_i[1] ##1 s_rd(8'h18) |=>
    bus_rdata_o[0]) else $error("latch missed a press");
  latch_clear_a: assert property (s_rd_free ##1 !key_i[1] ##1 s_rd_free
    |=> !bus_rdata_o[0]) else $error("latch not cleared by read");
  filter_rb_a: assert property (s_wr(OFS_FILTER) ##2 s_rd(OFS_FILTER)
    |=> bus_rdata_o[0] == $past(bus_wdata_i[0], 3))
    else $error("filter bit not kept");
  clamp_top_a: assert property (s_big ##2 s_rd(OFS_FACT) |=>
    bus_rdata_o == 32'h7d0) else $error("factor not clamped");
  pass_time_a: assert property (inc_strobe_i |-> ##[9:17] travel_valid_o)
    else $error("travel pass late");
endmodule : hil_hand_input_asserts

bind hil_hand_input hil_hand_input_asserts u_chk (
  .clock_i        (clock_i),
  .rst_b_i        (rst_b_i),
  .bus_addr_i     (bus_addr_i),
  .bus_wdata_i    (bus_wdata_i),
  .bus_wr_i       (bus_wr_i),
  .bus_rd_i       (bus_rd_i),
  .bus_rdata_o    (bus_rdata_o),
  .key_i          (key_i),
  .inc_strobe_i   (inc_strobe_i),
  .travel_valid_o (travel_valid_o)
);
`default_nettype wire

// ==== hil_hdi_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hil_hdi_model (
  input  wire logic                                clock_i,
  output logic      [hil_pkg::KEYS-1:0]            key_o,
  output logic                                     fsw_present_o,
  output logic                                     fsw_alt_o,
  output logic                                     strobe_o,
  output logic      [hil_pkg::AXES-1:0][hil_pkg::IW-1:0] hw_o,
  output logic      [hil_pkg::AXES-1:0][hil_pkg::IW-1:0] tb_o
);
  import hil_pkg::*;
  // Idle device: keys up, no switch, no motion
  initial begin
    key_o = '0;
    fsw_present_o = 1'b0;
    fsw_alt_o = 1'b0;
    strobe_o = 1'b0;
    hw_o = '0;
    tb_o = '0;
  end
  task automatic set_keys(input logic [KEYS-1:0] k);
    @(posedge clock_i);
    key_o <= k;
  endtask : set_keys
  task automatic set_sw(input logic p, input logic a);
    @(posedge clock_i);
    fsw_present_o <= p;
    fsw_alt_o <= a;
  endtask : set_sw
  // Counts mean nothing off the strobe, so the lines flip afterwards
  task automatic turn(input logic [AXES-1:0][IW-1:0] hw,
                      input logic [AXES-1:0][IW-1:0] tb);
    @(posedge clock_i);
    strobe_o <= 1'b1;
    hw_o <= hw;
    tb_o <= tb;
    @(posedge clock_i);
    strobe_o <= 1'b0;
    hw_o <= ~hw;
    tb_o <= ~tb;
  endtask : turn
endmodule : hil_hdi_model
`default_nettype wire

// ==== hil_hand_input_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module hil_hand_input_tb_top;
  import hil_pkg::*;
  logic                   clock_i;
  logic                   rst_b_i;
  logic [AW-1:0]          addr;
  logic [DW-1:0]          wdata;
  logic                   wr_s;
  logic                   rd_s;
  wire logic [DW-1:0]     rdata;
  wire logic [KEYS-1:0]   key;
  wire logic              fsw_p;
  wire logic              fsw_a;
  wire logic              stb;
  wire logic [AXES-1:0][IW-1:0] hw_inc;
  wire logic [AXES-1:0][IW-1:0] tb_inc;
  wire logic [AXES-1:0][TW-1:0] hw_tr;
  wire logic [AXES-1:0][TW-1:0] tb_tr;
  wire logic              tv;
  int                     miscompares;
  int                     n_tests;
  logic [15:0]            seed;
  logic [DW-1:0]          d;
  logic [AXES-1:0][IW-1:0] hw;
  logic [AXES-1:0][IW-1:0] tb;
  int                     fa [AXES];
  int                     fb [AXES];
  int                     g [AXES];
  int                     fh;

  hil_hand_input u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr_s),
    .bus_rd_i(rd_s), .bus_rdata_o(rdata), .key_i(key),
    .fsw_present_i(fsw_p), .fsw_alt_i(fsw_a), .inc_strobe_i(stb),
    .hw_inc_i(hw_inc), .tb_inc_i(tb_inc), .hw_travel_o(hw_tr),
    .tb_travel_o(tb_tr), .travel_valid_o(tv));
  hil_hdi_model u_hdi (.clock_i(clock_i), .key_o(key),
    .fsw_present_o(fsw_p), .fsw_alt_o(fsw_a), .strobe_o(stb),
    .hw_o(hw_inc), .tb_o(tb_inc));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction : lfsr
  function automatic logic [TW-1:0] mul(input logic [IW-1:0] a, int f);
    return TW'($signed(a) * f);
  endfunction : mul
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // One pass; eh carries the steps expected after filtering
  task automatic run(input logic [AXES-1:0][IW-1:0] eh, input int f [AXES]);
    int n;
    u_hdi.turn(hw, tb);
    for (n = 0; n < 30 && tv !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    if (n == 30) begin
      miscompares++;
      print_verdict;
    end
    for (int i = 0; i < AXES; i++) begin
      `CHK(hw_tr[i], mul(eh[i], f[i]) * HW_NM_SCALE)
      `CHK(tb_tr[i], mul(tb[i], g[i]))
    end
  endtask : run

  initial begin
    miscompares = 0;
    n_tests = 0;
    seed = 16'h002c;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    rst_b_i = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(OFS_FILTER, d);
    `CHK(d, 32'h1)
    for (int i = 0; i < MDEPTH; i++) begin
      rd(OFS_FACT + 8'(4 * i), d);
      `CHK(d, 32'ha)
    end
    rd(OFS_LATCH, d);
    `CHK(d, 32'h400)
    $display("test reset done");
    u_hdi.set_keys(4'h2);
    rd(OFS_KEY_NOW, d);
    `CHK(d, 32'h2)
    u_hdi.set_keys(4'h0);
    rd(8'h18, d);
    `CHK(d, 32'h101)
    rd(8'h18, d);
    `CHK(d, 32'h100)
    u_hdi.set_keys(4'h5);
    u_hdi.set_keys(4'h0);
    wr(8'h14, '0);
    rd(OFS_LATCH, d);
    `CHK(d, 32'h404)
    rd(OFS_LATCH, d);
    `CHK(d, 32'h400)
    u_hdi.set_keys(4'h8);
    wr(OFS_LATCH, '0);
    rd(8'h20, d);
    `CHK(d, 32'h101)
    u_hdi.set_keys(4'h0);
    wr(8'h20, '0);
    rd(8'h20, d);
    `CHK(d, 32'h100)
    $display("test latches done");
    // Raw steps first, so no filter residue is left behind
    wr(OFS_FILTER, 32'h0);
    rd(OFS_FILTER, d);
    `CHK(d, 32'h0)
    for (int it = 0; it < 4; it++) begin
      seed = lfsr(seed);
      fh = (it == 0) ? -2000 : (it == 1) ? 2000 : int'($signed(seed[10:0]));
      wr(OFS_HW_ALL, DW'(fh));
      for (int i = 0; i < AXES; i++) begin
        fa[i] = fh;
        fb[i] = -25;
        seed = lfsr(seed);
        g[i] = int'($signed(seed[8:0]));
        wr(OFS_FACT + 8'h20 + 8'(4 * i), DW'(g[i]));
        seed = lfsr(seed);
        hw[i] = seed[7:0];
        tb[i] = seed[15:8];
      end
      run(hw, fa);
    end
    $display("test scaling done");
    wr(OFS_HWB_ALL, 32'hffffffe7);
    u_hdi.set_sw(1'b1, 1'b1);
    rd(OFS_STATUS, d);
    `CHK(d, 32'h6)
    run(hw, fb);
    u_hdi.set_sw(1'b0, 1'b1);
    run(hw, fa);
    $display("test switch done");
    wr(OFS_FILTER, 32'h1);
    hw = {8'h3, 8'h3, 8'h3, 8'h3};
    run({8'h3, 8'h3, 8'h2, 8'h2}, fa);
    hw = {8'h1, 8'h1, 8'h1, 8'h1};
    run({8'h1, 8'h1, 8'h2, 8'h2}, fa);
    $display("test filter done");
    wr(OFS_FACT, 32'd3000);
    rd(OFS_FACT, d);
    `CHK(d, 32'h7d0)
    wr(OFS_FACT, 32'hfffff448);
    rd(OFS_FACT, d);
    `CHK(d, 32'hfffff830)
    rd(8'hfc, d);
    `CHK(d, 32'h0)
    $display("test range done");
    print_verdict;
  end
endmodule : hil_hand_input_tb_top
`default_nettype wire
